// >>> rtl/pfc_codec.sv
// repair header codec: header builder, header parser and AHB-Lite registers
//
// Notes on behaviour
// - grid variant carries columns and rows
// - one base/columns/rows block per stream
// - both zero: use session columns, rows
// - zero rows means row repairs only
// - one row: row and column repairs
// - all row repairs before any column
// - more rows: column repairs only
// - retransmit variant resends one source packet
// - source sequence replaces length field
// - source stream id inside the header
// - one repair stream serves many sources
// - drop source 12 bytes, prepend header
// - retransmit header laid out as RTP
// - protection type codes; reject multiple
// - session columns and rows positive, shared
// - repair span held in microseconds
// - never send both flags; drop them
// - recovery fields rebuild recovered header
// - base is lowest sequence, wrapping
`timescale 1ns/1ps
module pfc_codec import pfc_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // source packet bytes for retransmission
  input wire logic [7:0] src_data_i,
  input wire logic src_valid_i,
  input wire logic src_last_i,
  output logic src_ready_o,
  // repair packet bytes out
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  // repair header bytes in
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  // first word of a recovered packet
  output logic [31:0] rec_word_o
);
  pfc_grid_if gi ();
  pfc_grid_plan u_plan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .gp(gi.plan)
  );

  logic a_wr;
  logic a_rd;
  logic a_hit;
  logic [7:0] a_addr;
  logic [3:0] top_list;
  logic [31:0] rate;
  logic [31:0] span;
  pfc_dim_t cfg_l;
  pfc_dim_t cfg_d;
  logic [29:0] hdr;
  logic [31:0] ts;
  logic [31:0] ssrc;
  logic [31:0] blk;
  logic refused;
  pfc_state_t st;
  logic is_retx;
  logic src_done;
  logic [3:0] cnt;
  logic [95:0] sh;
  logic in_cols;
  pfc_dim_t grp_idx;
  logic [15:0] grp_off;
  logic [31:0] rx_sh;
  logic [5:0] rx_cnt;
  logic rx_drop;
  logic [1:0] rx_kind;
  logic rx_mask_seen;
  logic [31:0] rx_w0;
  logic [31:0] rx_w1;
  logic [31:0] rx_w2;
  logic [7:0] rx_bad_cnt;
  logic [7:0] rx_frames;
  logic [3:0] rx_blocks;

  logic accept;
  logic wr_ctrl;
  logic sched_rst;
  logic top_multi;
  logic cfg_ok;
  logic rate_ok;
  logic start;
  logic start_ok;
  logic take;
  logic tx_free;
  logic hdr_load;
  logic hdr_end;
  logic cur_col;
  logic [15:0] grp_base;
  logic next_src_ready;
  logic rx_take;
  logic word_done;
  logic [31:0] wd;
  logic [3:0] widx;
  logic drop_now;
  logic [31:0] rd_mux;

  assign gi.hdr_l = blk[`PFC_BF_L];
  assign gi.hdr_d = blk[`PFC_BF_D];
  assign gi.cfg_l = cfg_l;
  assign gi.cfg_d = cfg_d;

  // bus slave
  assign accept = hsel_i && hready_i && htrans_i[1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_wr <= 1'b0;
      a_rd <= 1'b0;
      a_hit <= 1'b0;
      a_addr <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= '0;
    end else begin
      a_wr <= accept && hwrite_i;
      a_rd <= accept && !hwrite_i;
      if (accept) begin
        a_addr <= haddr_i[`PFC_ADDR_LO];
        a_hit <= haddr_i[`PFC_ADDR_HI] == '0;
      end
      hreadyout_o <= a_rd || !(accept && !hwrite_i);
      if (a_rd) begin
        hrdata_o <= a_hit ? rd_mux : '0;
      end
    end
  end

  assign wr_ctrl = a_wr && a_hit && a_addr == `PFC_A_CTRL;
  assign sched_rst = a_wr && a_hit && (a_addr == `PFC_A_BLK || a_addr == `PFC_A_DIMS);

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_list <= '0;
      rate <= '0;
      span <= '0;
      cfg_l <= '0;
      cfg_d <= '0;
      hdr <= '0;
      ts <= '0;
      ssrc <= '0;
      blk <= '0;
    end else if (a_wr && a_hit) begin
      unique case (a_addr)
        `PFC_A_TOP: top_list <= hwdata_i[`PFC_TOP_F];
        `PFC_A_RATE: rate <= hwdata_i;
        `PFC_A_SPAN: span <= hwdata_i;
        `PFC_A_DIMS: begin
          cfg_l <= hwdata_i[`PFC_BF_L];
          cfg_d <= hwdata_i[`PFC_BF_D];
        end
        `PFC_A_HDR: hdr <= hwdata_i[`PFC_HF_SW];
        `PFC_A_TS: ts <= hwdata_i;
        `PFC_A_SSRC: ssrc <= hwdata_i;
        `PFC_A_BLK: blk <= hwdata_i;
        default: ;
      endcase
    end
  end

  assign top_multi = (top_list & (top_list - 4'h1)) != '0;
  assign cfg_ok = !top_multi && cfg_l != '0 && cfg_d != '0;
  assign rate_ok = rate > `PFC_RATE_MIN;

  assign start = wr_ctrl && hwdata_i[`PFC_C_START] && st == ST_IDLE;
  always_comb begin
    if (hwdata_i[`PFC_C_RETX]) begin
      start_ok = !top_multi && (top_list == '0 || top_list[`PFC_TOP_RETX]);
    end else begin
      start_ok = cfg_ok && gi.mode != GM_NONE
        && (top_list == '0 || top_list[gi.top_kind]);
    end
  end

  // refused start flag, a new refusal wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused <= 1'b0;
    end else if ((wr_ctrl && hwdata_i[`PFC_C_START] && st != ST_IDLE) || (start && !start_ok)) begin
      refused <= 1'b1;
    end else if (wr_ctrl && hwdata_i[`PFC_C_CLR]) begin
      refused <= 1'b0;
    end
  end

  // builder
  assign tx_free = !tx_valid_o || tx_ready_i;
  assign take = src_valid_i && src_ready_o;
  assign hdr_load = st == ST_HDR && tx_free;
  assign hdr_end = hdr_load && cnt == `PFC_LAST_BYTE;
  assign cur_col = in_cols || gi.n_rows == '0;
  // lowest sequence with 16 bit wrap
  assign grp_base = blk[`PFC_BF_BASE] + grp_off;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      is_retx <= 1'b0;
      src_done <= 1'b0;
      cnt <= '0;
      sh <= '0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          cnt <= '0;
          src_done <= 1'b0;
          if (start && start_ok) begin
            is_retx <= hwdata_i[`PFC_C_RETX];
            if (hwdata_i[`PFC_C_RETX]) begin
              // sequence in length place, source id in header
              sh <= {`PFC_VER_RETX, hdr[`PFC_HF_FLAGS], blk[`PFC_BF_BASE], ts, ssrc};
              st <= ST_SKIP;
            end else begin
              // columns and rows replace the mask
              sh <= {`PFC_VER_GRID, hdr, ts, grp_base, blk[`PFC_BF_LD]};
              st <= ST_HDR;
            end
          end
        end
        ST_SKIP: begin
          if (take) begin
            cnt <= cnt + 4'h1;
            if (cnt == `PFC_LAST_BYTE) begin
              cnt <= '0;
              src_done <= src_last_i;
              st <= ST_HDR;
            end else if (src_last_i) begin
              cnt <= '0;
              src_done <= 1'b1;
              st <= ST_HDR;
            end
          end
        end
        ST_HDR: begin
          if (hdr_load) begin
            sh <= {sh[87:0], 8'h00};
            cnt <= cnt + 4'h1;
            if (hdr_end) begin
              st <= (is_retx && !src_done) ? ST_PAY : ST_IDLE;
            end
          end
        end
        ST_PAY: begin
          if (take && src_last_i) begin
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // byte output register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
      tx_data_o <= '0;
    end else if (hdr_load) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= sh[95:88];
      tx_last_o <= hdr_end && (!is_retx || src_done);
    end else if (st == ST_PAY && take) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= src_data_i;
      tx_last_o <= src_last_i;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // source ready is raised in ST_SKIP, and in ST_PAY only while the output register can take a byte
  assign next_src_ready = !take && (st == ST_SKIP || (st == ST_PAY && tx_free));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_ready_o <= 1'b0;
    end else begin
      src_ready_o <= next_src_ready;
    end
  end

  // repair schedule of the grid variant
  always_ff @(posedge clk_i) begin
    if (rst_i || sched_rst) begin
      in_cols <= 1'b0;
      grp_idx <= '0;
      grp_off <= '0;
    end else if (hdr_end && !is_retx) begin
      if (!cur_col) begin
        if (pfc_dim_t'(grp_idx + 1'b1) < gi.n_rows) begin
          grp_idx <= grp_idx + 1'b1;
          grp_off <= grp_off + 16'(gi.eff_l);
        end else begin
          // columns only after the last row
          in_cols <= gi.n_cols != '0;
          grp_idx <= '0;
          grp_off <= '0;
        end
      end else if (pfc_dim_t'(grp_idx + 1'b1) < gi.n_cols) begin
        grp_idx <= grp_idx + 1'b1;
        grp_off <= grp_off + 16'h0001;
      end else begin
        in_cols <= 1'b0;
        grp_idx <= '0;
        grp_off <= '0;
      end
    end
  end

  // parser
  assign rx_take = rx_valid_i && rx_ready_o;
  assign word_done = rx_take && rx_cnt[1:0] == 2'h3;
  assign wd = {rx_sh[23:0], rx_data_i};
  assign widx = rx_cnt[5:2];
  assign drop_now = (word_done && widx == `PFC_RX_W0) ? wd[`PFC_HF_RF] == `PFC_VER_BAD : rx_drop;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ready_o <= 1'b0;
      rx_sh <= '0;
      rx_cnt <= '0;
      rx_drop <= 1'b0;
      rx_kind <= `PFC_VER_MASK;
      rx_mask_seen <= 1'b0;
      rx_w0 <= '0;
      rx_w1 <= '0;
      rx_w2 <= '0;
      rx_bad_cnt <= '0;
      rx_frames <= '0;
      rx_blocks <= '0;
      rec_word_o <= '0;
    end else begin
      rx_ready_o <= 1'b1;
      if (rx_take) begin
        rx_sh <= wd;
        if (rx_last_i) begin
          rx_cnt <= '0;
        end else if (rx_cnt != `PFC_RX_SAT) begin
          rx_cnt <= rx_cnt + 6'h01;
        end
        if (word_done && !drop_now) begin
          if (widx == `PFC_RX_W0) begin
            rx_w0 <= wd;
            rx_kind <= wd[`PFC_HF_RF];
            rx_mask_seen <= rx_mask_seen || wd[`PFC_HF_RF] == `PFC_VER_MASK;
            if (wd[`PFC_HF_RF] != `PFC_VER_RETX) begin
              rec_word_o <= {`PFC_VER_RTP, wd[`PFC_HF_FLAGS], `PFC_SEQ_ZERO};
            end
          end else if (widx == `PFC_RX_W1) begin
            rx_w1 <= wd;
          end else if (widx == `PFC_RX_W2) begin
            rx_w2 <= wd;
            rx_blocks <= 4'h1;
          end else if (rx_kind == `PFC_VER_GRID && rx_blocks != 4'hF) begin
            rx_blocks <= rx_blocks + 4'h1;
          end
        end
        if (rx_last_i) begin
          rx_drop <= 1'b0;
          if (drop_now) begin
            rx_bad_cnt <= rx_bad_cnt + 8'h01;
          end else begin
            rx_frames <= rx_frames + 8'h01;
          end
        end else begin
          rx_drop <= drop_now;
        end
      end
    end
  end

  // read multiplexer
  always_comb begin
    rd_mux = '0;
    unique case (a_addr)
      `PFC_A_TOP: rd_mux = {28'h0000000, top_list};
      `PFC_A_RATE: rd_mux = rate;
      `PFC_A_SPAN: rd_mux = span;
      `PFC_A_DIMS: rd_mux = {16'h0000, cfg_l, cfg_d};
      `PFC_A_HDR: rd_mux = {2'h0, hdr};
      `PFC_A_TS: rd_mux = ts;
      // one repair stream id for all sources
      `PFC_A_SSRC: rd_mux = ssrc;
      `PFC_A_BLK: rd_mux = blk;
      `PFC_A_STAT: rd_mux = {2'h0, gi.mode, rx_blocks, rx_frames, rx_bad_cnt, rx_kind,
        rx_mask_seen, rate_ok, cfg_ok, top_multi, refused, st != ST_IDLE};
      `PFC_A_RXW0: rd_mux = rx_w0;
      `PFC_A_RXW1: rd_mux = rx_w1;
      `PFC_A_RXW2: rd_mux = rx_w2;
      `PFC_A_SCHED: rd_mux = {7'h00, cur_col, grp_idx, grp_base};
      default: rd_mux = '0;
    endcase
  end
endmodule : pfc_codec

// >>> rtl/pfc_defs.svh
// constants of the repair header codec: offsets, fields, codes and counts
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
`define PFC_A_CTRL 8'h00
`define PFC_A_TOP 8'h04
`define PFC_A_RATE 8'h08
`define PFC_A_SPAN 8'h0C
`define PFC_A_DIMS 8'h10
`define PFC_A_HDR 8'h14
`define PFC_A_TS 8'h18
`define PFC_A_SSRC 8'h1C
`define PFC_A_BLK 8'h20
`define PFC_A_STAT 8'h24
`define PFC_A_RXW0 8'h28
`define PFC_A_RXW1 8'h2C
`define PFC_A_RXW2 8'h30
`define PFC_A_SCHED 8'h34
`define PFC_C_START 0
`define PFC_C_RETX 1
`define PFC_C_CLR 2
`define PFC_HF_RF 31:30
`define PFC_HF_FLAGS 29:16
`define PFC_HF_SW 29:0
`define PFC_BF_BASE 31:16
`define PFC_BF_LD 15:0
`define PFC_BF_L 15:8
`define PFC_BF_D 7:0
`define PFC_TOP_F 3:0
`define PFC_VER_MASK 2'h0
`define PFC_VER_GRID 2'h1
`define PFC_VER_RETX 2'h2
`define PFC_VER_BAD 2'h3
`define PFC_VER_RTP 2'h2
`define PFC_TOP_INTL 2'h0
`define PFC_TOP_NONINTL 2'h1
`define PFC_TOP_TWOD 2'h2
`define PFC_TOP_RETX 2'h3
`define PFC_RATE_MIN 32'h000003E8
`define PFC_LAST_BYTE 4'hB
`define PFC_RX_SAT 6'h3F
`define PFC_RX_W0 4'h0
`define PFC_RX_W1 4'h1
`define PFC_RX_W2 4'h2
`define PFC_LD_W 8
`define PFC_SEQ_ZERO 16'h0000
`define PFC_ADDR_HI 31:8
`define PFC_ADDR_LO 7:0
`endif

// >>> rtl/pfc_grid_if.sv
// grid dimension signals between the codec and its grid planner
`timescale 1ns/1ps
interface pfc_grid_if import pfc_pkg::*; ();
  pfc_dim_t hdr_l;
  pfc_dim_t hdr_d;
  pfc_dim_t cfg_l;
  pfc_dim_t cfg_d;
  pfc_dim_t eff_l;
  pfc_dim_t col_span;
  pfc_dim_t n_rows;
  pfc_dim_t n_cols;
  pfc_mode_t mode;
  logic [1:0] top_kind;
  modport plan (input hdr_l, input hdr_d, input cfg_l, input cfg_d,
    output eff_l, output col_span, output n_rows, output n_cols, output mode, output top_kind);
  modport user (output hdr_l, output hdr_d, output cfg_l, output cfg_d,
    input eff_l, input col_span, input n_rows, input n_cols, input mode, input top_kind);
endinterface : pfc_grid_if

// >>> rtl/pfc_grid_plan.sv
// grid planner: effective columns and rows and the resulting repair mode
`timescale 1ns/1ps
module pfc_grid_plan import pfc_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // dimensions in and plan out
  pfc_grid_if.plan gp
);
  pfc_dim_t next_l;
  pfc_dim_t next_d;
  pfc_mode_t next_mode;

  always_comb begin
    if (gp.hdr_l == '0 && gp.hdr_d == '0) begin
      next_l = gp.cfg_l;
      next_d = gp.cfg_d;
    end else begin
      next_l = gp.hdr_l;
      next_d = gp.hdr_d;
    end
    if (next_l == '0) begin
      next_mode = GM_NONE;
    end else if (next_d == '0) begin
      next_mode = GM_ROW;
    end else if (next_d == pfc_dim_t'(1)) begin
      next_mode = GM_ROWCOL;
    end else begin
      next_mode = GM_COL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gp.eff_l <= '0;
      gp.col_span <= '0;
      gp.n_rows <= '0;
      gp.n_cols <= '0;
      gp.mode <= GM_NONE;
      gp.top_kind <= `PFC_TOP_NONINTL;
    end else begin
      gp.eff_l <= next_l;
      gp.mode <= next_mode;
      gp.n_rows <= (next_mode == GM_ROW || next_mode == GM_ROWCOL) ? gp.cfg_d : '0;
      gp.n_cols <= (next_mode == GM_ROWCOL || next_mode == GM_COL) ? next_l : '0;
      gp.col_span <= (next_mode == GM_COL) ? next_d : gp.cfg_d;
      unique case (next_mode)
        GM_COL: gp.top_kind <= `PFC_TOP_INTL;
        GM_ROWCOL: gp.top_kind <= `PFC_TOP_TWOD;
        GM_ROW, GM_NONE: gp.top_kind <= `PFC_TOP_NONINTL;
      endcase
    end
  end
endmodule : pfc_grid_plan

// >>> rtl/pfc_pkg.sv
// types shared by the repair header codec modules
`include "pfc_defs.svh"
package pfc_pkg;
  typedef logic [`PFC_LD_W-1:0] pfc_dim_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_HDR, ST_PAY} pfc_state_t;
  typedef enum logic [1:0] {GM_NONE, GM_ROW, GM_ROWCOL, GM_COL} pfc_mode_t;
endpackage : pfc_pkg

// >>> verif/pfc_codec_properties.sv
// port checker of the repair header codec
`timescale 1ns/1ps
module pfc_codec_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and streams
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic src_valid_i,
  input wire logic src_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic rx_ready_o,
  input wire logic [31:0] rec_word_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic sof;
  logic grid;
  logic [11:0] cnt;
  // frame start, variant and byte count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sof <= 1'b1;
      grid <= 1'b0;
      cnt <= 12'h000;
    end else if (tx_valid_o && tx_ready_i) begin
      sof <= tx_last_o;
      cnt <= tx_last_o ? 12'h000 : cnt + 12'h001;
      if (sof) begin
        grid <= (tx_data_o[7:6] == 2'b01);
      end
    end
  end
  hold_tx_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("tx byte changed while stalled");
  first_flags_a: assert property (
    sof && tx_valid_o |-> tx_data_o[7:6] == 2'b01 || tx_data_o[7:6] == 2'b10)
    else $error("bad flags in first tx byte");
  frame_len_a: assert property (
    tx_valid_o && tx_ready_i && tx_last_o |-> cnt >= 12'h00B && (!grid || cnt == 12'h00B))
    else $error("repair frame length wrong");
  src_pace_a: assert property (
    src_ready_o && src_valid_i |=> !src_ready_o)
    else $error("source byte taken twice in a row");
  rec_low_a: assert property (
    rec_word_o[15:0] == 16'h0000)
    else $error("recovered word low half not zero");
  rec_ver_a: assert property (
    rec_word_o != 32'h00000000 |-> rec_word_o[31:30] == 2'b10)
    else $error("recovered word version wrong");
  read_wait_a: assert property (
    hsel_i && hready_i && htrans_i[1] && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  rx_open_a: assert property (
    !$past(rst_i) |-> rx_ready_o)
    else $error("header input not ready");
endmodule : pfc_codec_properties
bind pfc_codec pfc_codec_properties u_pfc_codec_properties (.clk_i(clk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
  .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
  .rx_ready_o(rx_ready_o), .rec_word_o(rec_word_o));

// >>> verif/pfc_remote_model.sv
// remote endpoint model: repair packet sink, repair header source
`timescale 1ns/1ps
module pfc_remote_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // repair bytes from the codec
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  // header bytes to the codec
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_last_o,
  input wire logic rx_ready_i,
  // stall mode
  input wire logic slow_i
);
  logic [7:0] got [$];
  logic [1:0] tick;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
  end
  always_ff @(posedge clk_i) begin
    tick <= rst_i ? 2'h0 : tick + 2'h1;
    tx_ready_o <= !slow_i || (tick == 2'h3);
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  task automatic send(input logic [95:0] hdr);
    for (int i = 11; i >= 0; i--) begin
      rx_data_o <= hdr[i*8 +: 8];
      rx_valid_o <= 1'b1;
      rx_last_o <= (i == 0);
      @(posedge clk_i);
      while (!rx_ready_i) @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~hdr[7:0];
  endtask : send
endmodule : pfc_remote_model

// >>> verif/tb_parity_fec_header_codec.sv
// self-checking bench of the repair header codec
`timescale 1ns/1ps
module tb_parity_fec_header_codec;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] msk;
    logic [31:0] exp;
  } pfc_row_t;
  pfc_row_t rows [11] = '{
    '{8'h08, 32'h3E8, 8'h24, 32'h10, 32'h0}, '{8'h08, 32'h3E9, 8'h24, 32'h10, 32'h10},
    '{8'h0C, 32'h1234, 8'h0C, 32'hFFFFFFFF, 32'h1234}, '{8'h04, 32'h3, 8'h24, 32'h4, 32'h4},
    '{8'h04, 32'h0, 8'h24, 32'h4, 32'h0}, '{8'h10, 32'h0, 8'h24, 32'h8, 32'h0},
    '{8'h10, 32'h402, 8'h24, 32'h8, 32'h8},
    '{8'h20, 32'h50400, 8'h24, 32'h30000000, 32'h10000000},
    '{8'h20, 32'h50403, 8'h24, 32'h30000000, 32'h30000000},
    '{8'h20, 32'h50401, 8'h24, 32'h30000000, 32'h20000000},
    '{8'h20, 32'h0, 8'h24, 32'h30000000, 32'h30000000}};
  logic [15:0] bases [5] = '{16'hFFFE, 16'h0001, 16'hFFFE, 16'hFFFF, 16'h0000};
  logic clk_i, rst_i, hsel_i, hwrite_i, src_valid_i, src_last_i, slow;
  logic [1:0] htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rec_word_o, rdat;
  logic [7:0] src_data_i, tx_data_o, rx_data;
  logic hreadyout_o, hresp_o, src_ready_o, tx_valid_o, tx_last_o, tx_ready;
  logic rx_valid, rx_last, rx_ready;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  pfc_codec u_pfc_codec (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .src_data_i(src_data_i), .src_valid_i(src_valid_i), .src_last_i(src_last_i),
    .src_ready_o(src_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_last_o(tx_last_o), .tx_ready_i(tx_ready), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_last_i(rx_last), .rx_ready_o(rx_ready), .rec_word_o(rec_word_o));
  pfc_remote_model u_pfc_remote_model (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_last_o(rx_last), .rx_ready_i(rx_ready), .slow_i(slow));
  task automatic finish_test();
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    @(posedge clk_i);
    while (!hreadyout_o) @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clk_i);
    while (!hreadyout_o) @(posedge clk_i);
    rdat = hrdata_o;
  endtask : ahb
  task automatic wait_bytes(input int n);
    while (u_pfc_remote_model.got.size() < n) @(posedge clk_i);
  endtask : wait_bytes
  task automatic src_send(input int n);
    for (int i = 0; i < n; i++) begin
      src_data_i <= 8'hA0 + 8'(i);
      src_valid_i <= 1'b1;
      src_last_i <= (i == n - 1);
      @(posedge clk_i);
      while (!src_ready_o) @(posedge clk_i);
    end
    src_valid_i <= 1'b0;
    src_last_i <= 1'b0;
    src_data_i <= 8'h50;
  endtask : src_send
  function automatic logic [31:0] word(input int i);
    word = {u_pfc_remote_model.got[4*i], u_pfc_remote_model.got[4*i+1],
      u_pfc_remote_model.got[4*i+2], u_pfc_remote_model.got[4*i+3]};
  endfunction : word
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    {rst_i, hsel_i, hwrite_i, src_valid_i, src_last_i, slow} = 6'h20;
    {htrans_i, haddr_i, hwdata_i, src_data_i} = 74'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      ahb(1'b1, 32'(rows[i].wa), rows[i].wd);
      ahb(1'b0, 32'(rows[i].ra), 32'h0);
      check($sformatf("row%0d", i), rdat & rows[i].msk, rows[i].exp);
    end
    slow <= 1'b1;
    ahb(1'b1, 32'h10, 32'h302);
    ahb(1'b1, 32'h20, 32'hFFFE0301);
    ahb(1'b1, 32'h14, 32'h0ABC1234);
    ahb(1'b1, 32'h18, 32'hCAFEF00D);
    ahb(1'b1, 32'h1C, 32'h13572468);
    foreach (bases[g]) begin
      ahb(1'b1, 32'h0, 32'h1);
      wait_bytes(12);
      check("gw0", word(0), 32'h4ABC1234);
      check("gw1", word(1), 32'hCAFEF00D);
      check("gw2", word(2), {bases[g], 16'h0301});
      u_pfc_remote_model.got.delete();
    end
    slow <= 1'b0;
    ahb(1'b1, 32'h0, 32'h3);
    src_send(16);
    wait_bytes(16);
    check("rw0", word(0), 32'h8ABCFFFE);
    check("rw2", word(2), 32'h13572468);
    check("rw3", word(3), 32'hACADAEAF);
    u_pfc_remote_model.got.delete();
    ahb(1'b1, 32'h4, 32'h3);
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b0, 32'h24, 32'h0);
    check("ref", rdat & 32'h2, 32'h2);
    ahb(1'b1, 32'h0, 32'h4);
    ahb(1'b1, 32'h4, 32'h8);
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b0, 32'h24, 32'h0);
    check("ref2", rdat & 32'h6, 32'h2);
    check("none", 32'(u_pfc_remote_model.got.size()), 32'h0);
    ahb(1'b1, 32'h10C, 32'hFFFF);
    ahb(1'b0, 32'h10C, 32'h0);
    check("unm", rdat, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    check("span", rdat, 32'h1234);
    check("resp", 32'(hresp_o), 32'h0);
    u_pfc_remote_model.send({32'h4DEF0010, 32'h11223344, 32'h00070302});
    ahb(1'b0, 32'h30, 32'h0);
    check("rxw2", rdat, 32'h00070302);
    check("rec", rec_word_o, 32'h8DEF0000);
    u_pfc_remote_model.send({32'hC0000000, 64'h0});
    ahb(1'b0, 32'h24, 32'h0);
    check("rxst", rdat & 32'h00FFFFC0, 32'h00010140);
    ahb(1'b0, 32'h28, 32'h0);
    check("rxw0", rdat, 32'h4DEF0010);
    u_pfc_remote_model.send({32'h00010000, 64'h0});
    ahb(1'b0, 32'h24, 32'h0);
    check("mask", rdat & 32'h00FF00E0, 32'h00020020);
    check("rec0", rec_word_o, 32'h80010000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ahb(1'b0, 32'h24, 32'h0);
    check("rst", rdat, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    check("rspan", rdat, 32'h0);
    check("rrec", rec_word_o, 32'h0);
    finish_test();
  end
endmodule : tb_parity_fec_header_codec
